// file: cssr_pkg.sv
// shared constants for the configuration serial slave and its bus master
package cssr_pkg;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned SCL_MAX_HZ    = 400_000;
	localparam int unsigned SCL_PERIOD_NS = 1_000_000_000 / SCL_MAX_HZ;
	localparam int unsigned SCL_QTR_CYC   = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DIV_W         = 5;

	// slave address: value is arbitrary
	localparam logic [6:0] DEV_ADDR       = 7'h2A;
	localparam logic [7:0] REG_RESET_CFG  = 8'h11;
	localparam logic [7:0] REG_RESET_NV   = 8'h31;
	localparam logic [7:0] CMD_REBOOT     = 8'hC4;
	localparam logic [7:0] RESET_CFG_RST  = 8'h00;
	localparam int unsigned RCFG_SEL_HI   = 7;
	localparam int unsigned RCFG_SEL_LO   = 4;
	localparam int unsigned RCFG_TMO_HI   = 3;
	localparam int unsigned RCFG_TMO_LO   = 1;

	localparam int unsigned TMO0_NS = 25_000;
	localparam int unsigned TMO1_NS = 12_500_000;
	localparam int unsigned TMO2_NS = 25_000_000;
	localparam int unsigned TMO3_NS = 50_000_000;
	localparam int unsigned TMO4_NS = 100_000_000;
	localparam int unsigned TMO5_NS = 200_000_000;
	localparam int unsigned TMO6_NS = 400_000_000;
	localparam int unsigned TMO7_NS = 1_600_000_000;
	localparam int unsigned TMO0_CYC = (TMO0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TMO1_CYC = (TMO1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TMO2_CYC = (TMO2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TMO3_CYC = (TMO3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TMO4_CYC = (TMO4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TMO5_CYC = (TMO5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TMO6_CYC = (TMO6_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TMO7_CYC = (TMO7_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TMR_W    = 26;

	localparam logic [3:0] HREG_CMD   = 4'h0;
	localparam logic [3:0] HREG_WDATA = 4'h1;
	localparam logic [3:0] HREG_CTRL  = 4'h2;
	localparam logic [3:0] HREG_STAT  = 4'h3;
	localparam logic [3:0] HREG_RX    = 4'h4;
	localparam logic [1:0] OP_WRITE   = 2'h1;
	localparam logic [1:0] OP_CMD     = 2'h2;
	localparam logic [1:0] OP_READ    = 2'h3;
	localparam int unsigned STAT_BUSY = 0;
	localparam int unsigned STAT_NAK  = 1;
	localparam int unsigned STAT_RXV  = 2;
	localparam logic [2:0] STEP_ADDR_W = 3'h0;
	localparam logic [2:0] STEP_CMD    = 3'h1;
	localparam logic [2:0] STEP_DATA   = 3'h2;
	localparam logic [2:0] STEP_SR     = 3'h3;
	localparam logic [2:0] STEP_ADDR_R = 3'h4;
	localparam logic [2:0] STEP_RX     = 3'h5;
endpackage : cssr_pkg

// file: cssr_if.sv
// two-wire link between the bus master and the configuration slave
`timescale 1ns/1ps
interface cssr_if;
	logic scl_o;
	logic scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// pulled-up wires: any enabled low driver wins
	assign scl = ~(scl_oe & ~scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output scl_o, output scl_oe,
		output host_sda_o, output host_sda_oe);
endinterface : cssr_if

// file: cssr_dev.sv
// configuration serial slave with reset-output selection and timeout
//
// Overview of operation
// - factory state: all configuration registers zero
// - host writes, verifies, then stores to nonvolatile
// - nonvolatile copy survives reset/power-up
// - reboot command reloads registers from nonvolatile
// - bits 7..4 include outputs 1..4 in reset
// - bits 3..1 choose the reset timeout
// - slave only, never drives the clock
// - works at any clock up to 400 kHz
// - start, address, command/data, stop framing
// - eight-bit bytes each followed by acknowledge
// - data change during clock high is start/stop
// - data pulled low only, clock input only
// - falling data start, rising data stop
// - repeated start keeps transaction open
// - stop ends transfer anywhere, except start interval
// - master separates start and stop by a clock
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module cssr_dev #(
	parameter int unsigned T1 = cssr_pkg::TMO1_CYC,
	parameter int unsigned T2 = cssr_pkg::TMO2_CYC,
	parameter int unsigned T3 = cssr_pkg::TMO3_CYC,
	parameter int unsigned T4 = cssr_pkg::TMO4_CYC,
	parameter int unsigned T5 = cssr_pkg::TMO5_CYC,
	parameter int unsigned T6 = cssr_pkg::TMO6_CYC,
	parameter int unsigned T7 = cssr_pkg::TMO7_CYC
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic factory_erase,
	input  wire logic [3:0] mon_good,
	output logic      reset_out_n,
	output logic [7:0] reset_cfg,
	cssr_if.dev       bus
);
	localparam int unsigned TW = cssr_pkg::TMR_W;

	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_ADDR  = 3'h1,
		S_AACK  = 3'h3,
		S_WBYTE = 3'h2,
		S_WACK  = 3'h6,
		S_RBYTE = 3'h7,
		S_RACK  = 3'h5
	} cssr_dev_st_e;

	typedef struct packed {
		logic         scl_m;
		logic         scl_s;
		logic         scl_p;
		logic         sda_m;
		logic         sda_s;
		logic         sda_p;
		cssr_dev_st_e st;
		logic [3:0]   bc;
		logic [7:0]   sh;
		logic         rw;
		logic         first;
		logic         nak;
		logic         shi;
		logic         sda_low;
		logic [7:0]   ptr;
		logic [7:0]   cfg;
		logic [7:0]   nv;
		logic [TW-1:0] tmr;
		logic         rst_n;
	} cssr_dev_s;

	cssr_dev_s r_reg;
	cssr_dev_s r_next;

	function automatic logic [TW-1:0] tmo_cyc(input logic [2:0] code);
		unique case (code)
			3'h0: tmo_cyc = TW'(cssr_pkg::TMO0_CYC);
			3'h1: tmo_cyc = TW'(T1);
			3'h2: tmo_cyc = TW'(T2);
			3'h3: tmo_cyc = TW'(T3);
			3'h4: tmo_cyc = TW'(T4);
			3'h5: tmo_cyc = TW'(T5);
			3'h6: tmo_cyc = TW'(T6);
			3'h7: tmo_cyc = TW'(T7);
		endcase
	endfunction : tmo_cyc

	// unmapped offsets read as zero
	function automatic logic [7:0] rd_val(input logic [7:0] a, input logic [7:0] c,
		input logic [7:0] n);
		if (a == cssr_pkg::REG_RESET_CFG)
			rd_val = c;
		else if (a == cssr_pkg::REG_RESET_NV)
			rd_val = n;
		else
			rd_val = 8'h00;
	endfunction : rd_val

	logic          scl_rise;
	logic          scl_fall;
	logic          start_c;
	logic          stop_c;
	logic          fault;
	logic [7:0]    rv;

	always_comb
	begin
		r_next = r_reg;
		r_next.scl_m = bus.scl;
		r_next.scl_s = r_reg.scl_m;
		r_next.scl_p = r_reg.scl_s;
		r_next.sda_m = bus.sda;
		r_next.sda_s = r_reg.sda_m;
		r_next.sda_p = r_reg.sda_s;
		scl_rise = r_reg.scl_s & ~r_reg.scl_p;
		scl_fall = ~r_reg.scl_s & r_reg.scl_p;
		start_c = r_reg.scl_s & r_reg.scl_p & r_reg.sda_p & ~r_reg.sda_s;
		stop_c = r_reg.scl_s & r_reg.scl_p & ~r_reg.sda_p & r_reg.sda_s;
		rv = rd_val(r_reg.ptr, r_reg.cfg, r_reg.nv);
		if (scl_fall)
			r_next.shi = 1'b0;
		if (start_c)
		begin
			// a repeated start keeps the pointer so a read can follow the command
			r_next.st = S_ADDR;
			r_next.bc = 4'h0;
			r_next.sda_low = 1'b0;
			r_next.shi = 1'b1;
		end
		else if (stop_c && !r_reg.shi)
		begin
			// a stop in the same high pulse as the start is illegal and ignored
			r_next.st = S_IDLE;
			r_next.sda_low = 1'b0;
		end
		else
		begin
			unique case (r_reg.st)
				S_IDLE:
				begin
					r_next.sda_low = 1'b0;
				end
				S_ADDR, S_WBYTE:
				begin
					if (scl_rise)
					begin
						r_next.sh = {r_reg.sh[6:0], r_reg.sda_s};
						r_next.bc = r_reg.bc + 4'h1;
					end
					else if (scl_fall && r_reg.bc == 4'h8)
					begin
						r_next.sda_low = 1'b1;
						if (r_reg.st == S_ADDR)
						begin
							r_next.rw = r_reg.sh[0];
							if (r_reg.sh[7:1] == cssr_pkg::DEV_ADDR)
								r_next.st = S_AACK;
							else
							begin
								r_next.st = S_IDLE;
								r_next.sda_low = 1'b0;
							end
						end
						else
						begin
							r_next.st = S_WACK;
							if (r_reg.first)
							begin
								r_next.first = 1'b0;
								r_next.ptr = r_reg.sh;
								if (r_reg.sh == cssr_pkg::CMD_REBOOT)
									r_next.cfg = r_reg.nv;
							end
							else
							begin
								r_next.ptr = r_reg.ptr + 8'h01;
								if (r_reg.ptr == cssr_pkg::REG_RESET_CFG)
									r_next.cfg = r_reg.sh;
								if (r_reg.ptr == cssr_pkg::REG_RESET_NV)
									r_next.nv = r_reg.sh;
							end
						end
					end
				end
				S_AACK, S_WACK:
				begin
					if (scl_fall)
					begin
						r_next.bc = 4'h0;
						if (r_reg.st == S_AACK && r_reg.rw)
						begin
							r_next.st = S_RBYTE;
							r_next.sh = rv;
							r_next.sda_low = ~rv[7];
							r_next.ptr = r_reg.ptr + 8'h01;
						end
						else
						begin
							r_next.st = S_WBYTE;
							r_next.sda_low = 1'b0;
							if (r_reg.st == S_AACK)
								r_next.first = 1'b1;
						end
					end
				end
				S_RBYTE:
				begin
					if (scl_fall)
					begin
						r_next.bc = r_reg.bc + 4'h1;
						r_next.sh = {r_reg.sh[6:0], 1'b0};
						if (r_reg.bc == 4'h7)
						begin
							r_next.st = S_RACK;
							r_next.sda_low = 1'b0;
						end
						else
							r_next.sda_low = ~r_reg.sh[6];
					end
				end
				S_RACK:
				begin
					if (scl_rise)
						r_next.nak = r_reg.sda_s;
					else if (scl_fall)
					begin
						r_next.bc = 4'h0;
						if (r_reg.nak)
							r_next.st = S_IDLE;
						else
						begin
							r_next.st = S_RBYTE;
							r_next.sh = rv;
							r_next.sda_low = ~rv[7];
							r_next.ptr = r_reg.ptr + 8'h01;
						end
					end
				end
				default:
				begin
					r_next.st = S_IDLE;
					r_next.sda_low = 1'b0;
				end
			endcase
		end
		if (factory_erase)
		begin
			r_next.nv = cssr_pkg::RESET_CFG_RST;
			r_next.cfg = cssr_pkg::RESET_CFG_RST;
		end
		// selected output bit order: cfg bit 7 is output 1
		fault = |(r_reg.cfg[cssr_pkg::RCFG_SEL_HI:cssr_pkg::RCFG_SEL_LO]
			& ~{mon_good[0], mon_good[1], mon_good[2], mon_good[3]});
		if (fault)
		begin
			r_next.tmr = '0;
			r_next.rst_n = 1'b0;
		end
		else if (r_reg.tmr < tmo_cyc(r_reg.cfg[cssr_pkg::RCFG_TMO_HI:cssr_pkg::RCFG_TMO_LO]))
		begin
			r_next.tmr = r_reg.tmr + TW'(1);
			r_next.rst_n = 1'b0;
		end
		else
			r_next.rst_n = 1'b1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			r_reg <= '0;
			r_reg.scl_m <= 1'b1;
			r_reg.scl_s <= 1'b1;
			r_reg.scl_p <= 1'b1;
			r_reg.sda_m <= 1'b1;
			r_reg.sda_s <= 1'b1;
			r_reg.sda_p <= 1'b1;
			// power-up loads the stored copy; the stored copy is untouched unless factory_erase clears it
			r_reg.nv <= factory_erase ? cssr_pkg::RESET_CFG_RST : r_reg.nv;
			r_reg.cfg <= factory_erase ? cssr_pkg::RESET_CFG_RST : r_reg.nv;
		end
		else
			r_reg <= r_next;
	end

	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = r_reg.sda_low;
	assign reset_out_n = r_reg.rst_n;
	assign reset_cfg = r_reg.cfg;
endmodule : cssr_dev

// file: cssr_host.sv
// two-wire bus master that configures the slave from a small register port
`timescale 1ns/1ps
module cssr_host (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	cssr_if.host            bus
);
	typedef enum logic [1:0] {
		H_IDLE  = 2'h0,
		H_START = 2'h1,
		H_BYTE  = 2'h3,
		H_STOP  = 2'h2
	} cssr_host_st_e;

	typedef struct packed {
		logic          sda_m;
		logic          sda_s;
		cssr_host_st_e st;
		logic [2:0]    step;
		logic [1:0]    ph;
		logic [4:0]    div;
		logic [3:0]    bc;
		logic [7:0]    sh;
		logic          scl;
		logic          sda;
		logic [1:0]    op;
		logic [3:0]    cnt;
		logic [7:0]    cmd;
		logic [7:0]    wd;
		logic          nak;
		logic [1:0][7:0] fm;
		logic          wp;
		logic          rp;
		logic [1:0]    fc;
		logic [7:0]    rdata;
	} cssr_host_s;

	cssr_host_s r_reg;
	cssr_host_s r_next;
	logic       tick;
	logic       rx;
	logic       f_ready;
	logic       pop;

	always_comb
	begin
		r_next = r_reg;
		r_next.sda_m = bus.sda;
		r_next.sda_s = r_reg.sda_m;
		r_next.rdata = 8'h00;
		rx = (r_reg.step == cssr_pkg::STEP_RX);
		f_ready = (r_reg.fc != 2'h2);
		pop = rd && addr == cssr_pkg::HREG_RX && r_reg.fc != 2'h0;
		// quarter-period tick keeps the clock at or under 400 kHz
		tick = (r_reg.div == 5'(cssr_pkg::SCL_QTR_CYC - 1));
		r_next.div = tick ? 5'h0 : r_reg.div + 5'h1;
		if (rd)
		begin
			unique case (addr)
				cssr_pkg::HREG_CMD:   r_next.rdata = r_reg.cmd;
				cssr_pkg::HREG_WDATA: r_next.rdata = r_reg.wd;
				cssr_pkg::HREG_STAT:
					r_next.rdata = {5'h00, r_reg.fc != 2'h0, r_reg.nak, r_reg.st != H_IDLE};
				cssr_pkg::HREG_RX:    r_next.rdata = r_reg.fm[r_reg.rp];
				default:              r_next.rdata = 8'h00;
			endcase
		end
		if (pop)
		begin
			r_next.rp = ~r_reg.rp;
			r_next.fc = r_reg.fc - 2'h1;
		end
		if (wr && r_reg.st == H_IDLE)
		begin
			if (addr == cssr_pkg::HREG_CMD)
				r_next.cmd = wdata;
			if (addr == cssr_pkg::HREG_WDATA)
				r_next.wd = wdata;
			if (addr == cssr_pkg::HREG_CTRL && wdata[1:0] != 2'h0)
			begin
				r_next.op = wdata[1:0];
				r_next.cnt = (wdata[7:4] == 4'h0) ? 4'h1 : wdata[7:4];
				r_next.st = H_START;
				r_next.step = cssr_pkg::STEP_ADDR_W;
				r_next.ph = 2'h0;
				r_next.div = 5'h0;
				r_next.nak = 1'b0;
			end
		end
		else if (tick && r_reg.st != H_IDLE)
		begin
			r_next.ph = r_reg.ph + 2'h1;
			unique case (r_reg.st)
				H_START:
				begin
					// works from idle and as a repeated start
					r_next.scl = (r_reg.ph == 2'h1) || (r_reg.ph == 2'h2);
					r_next.sda = (r_reg.ph <= 2'h1);
					if (r_reg.ph == 2'h3)
					begin
						r_next.st = H_BYTE;
						r_next.bc = 4'h0;
						r_next.sh = {cssr_pkg::DEV_ADDR, r_reg.step == cssr_pkg::STEP_SR};
						if (r_reg.step == cssr_pkg::STEP_SR)
							r_next.step = cssr_pkg::STEP_ADDR_R;
					end
				end
				H_BYTE:
				begin
					if (r_reg.ph == 2'h0 && r_reg.bc == 4'h0 && rx && !f_ready)
						r_next.ph = 2'h0;
					else if (r_reg.ph == 2'h0)
					begin
						r_next.scl = 1'b0;
						if (r_reg.bc == 4'h8)
							r_next.sda = rx ? (r_reg.cnt == 4'h1) : 1'b1;
						else
							r_next.sda = rx ? 1'b1 : r_reg.sh[7];
					end
					else if (r_reg.ph == 2'h1)
						r_next.scl = 1'b1;
					else if (r_reg.ph == 2'h2)
					begin
						if (r_reg.bc != 4'h8)
							r_next.sh = {r_reg.sh[6:0], r_reg.sda_s};
						else if (!rx)
							r_next.nak = r_reg.sda_s;
					end
					else
					begin
						r_next.scl = 1'b0;
						r_next.bc = r_reg.bc + 4'h1;
						if (r_reg.bc == 4'h8)
						begin
							r_next.st = H_BYTE;
							r_next.bc = 4'h0;
							if (!rx && r_reg.nak)
								r_next.st = H_STOP;
							else
							begin
								unique case (r_reg.step)
									cssr_pkg::STEP_ADDR_W:
									begin
										r_next.step = cssr_pkg::STEP_CMD;
										r_next.sh = r_reg.cmd;
									end
									cssr_pkg::STEP_CMD:
									begin
										r_next.step = cssr_pkg::STEP_DATA;
										r_next.sh = r_reg.wd;
										if (r_reg.op == cssr_pkg::OP_CMD)
											r_next.st = H_STOP;
										if (r_reg.op == cssr_pkg::OP_READ)
										begin
											r_next.step = cssr_pkg::STEP_SR;
											r_next.st = H_START;
										end
									end
									cssr_pkg::STEP_ADDR_R:
										r_next.step = cssr_pkg::STEP_RX;
									cssr_pkg::STEP_RX:
									begin
										r_next.fm[r_reg.wp] = r_reg.sh;
										r_next.wp = ~r_reg.wp;
										r_next.fc = r_next.fc + 2'h1;
										r_next.cnt = r_reg.cnt - 4'h1;
										if (r_reg.cnt == 4'h1)
											r_next.st = H_STOP;
									end
									default:
										r_next.st = H_STOP;
								endcase
							end
						end
					end
				end
				H_STOP:
				begin
					// at least one clock pulse has passed since the start
					r_next.scl = (r_reg.ph != 2'h0);
					r_next.sda = (r_reg.ph >= 2'h2);
					if (r_reg.ph == 2'h3)
						r_next.st = H_IDLE;
				end
				default:
					r_next.st = H_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			r_reg <= '0;
			r_reg.sda_m <= 1'b1;
			r_reg.sda_s <= 1'b1;
			r_reg.scl <= 1'b1;
			r_reg.sda <= 1'b1;
		end
		else
			r_reg <= r_next;
	end

	assign bus.scl_o = 1'b0;
	assign bus.scl_oe = ~r_reg.scl;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe = ~r_reg.sda;
	assign rdata = r_reg.rdata;
endmodule : cssr_host

// file: cssr_asserts.sv
// protocol assertions on the two-wire link between the bus master and the slave
`timescale 1ns/1ps
module cssr_asserts (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence start_seen;
		scl && $fell(sda);
	endsequence
	sequence stop_seen;
		scl && $rose(sda);
	endsequence

	AST_DEV_DRIVE_LOW: assert property (dev_sda_oe |-> !dev_sda_o)
		else $error("slave drives the data line high");
	AST_HOST_DRIVE_LOW: assert property (!scl_o && !host_sda_o)
		else $error("master output level is not low");
	AST_IDLE_AFTER_RESET: assert property ($fell(rst) |-> !dev_sda_oe && !scl_oe && !host_sda_oe)
		else $error("a line is still driven after reset");
	// the slave is synchronised, so its changes come a few cycles into the low phase
	AST_DEV_CHANGE_SCL_LOW: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl) && !$past(scl, 2))
		else $error("slave data changed while the clock was high");
	AST_START_THEN_CLOCK: assert property (start_seen |-> ##[1:150] !scl)
		else $error("no clock pulse follows a start");
	AST_START_NO_STOP: assert property (start_seen |=> !sda until !scl)
		else $error("stop inside the same clock-high interval as start");
	AST_STOP_RELEASE: assert property (stop_seen |=> !dev_sda_oe [*8])
		else $error("slave drives the data line after stop");
	AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	AST_SCL_LOW_MIN: assert property ($fell(scl) |-> !scl [*8])
		else $error("clock low phase too short");

	COV_START: cover property (start_seen);
	COV_STOP: cover property (stop_seen);
	COV_DEV_DRIVE: cover property ($rose(dev_sda_oe));
endmodule : cssr_asserts

// file: cssr_tb_top.sv
// self-checking bench: host register port driving the slave over the link
`timescale 1ns/1ps
module cssr_tb_top;
	localparam int unsigned TMO_T [8] = '{cssr_pkg::TMO0_CYC, 40, 80, 120, 160, 200, 240, 280};
	logic       clk_sys;
	logic       rst;
	logic       factory_erase;
	logic [3:0] mon_good;
	logic       reset_out_n;
	logic [7:0] reset_cfg;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic [7:0] v;
	int         errors;
	int         comparisons;
	int         n;
	int         cnt;

	cssr_if bus ();
	// short timeout counts keep the run small
	cssr_dev #(.T1(TMO_T[1]), .T2(TMO_T[2]), .T3(TMO_T[3]), .T4(TMO_T[4]),
		.T5(TMO_T[5]), .T6(TMO_T[6]), .T7(TMO_T[7])) cssr_dev_i (
		.clk_sys(clk_sys), .rst(rst), .factory_erase(factory_erase), .mon_good(mon_good),
		.reset_out_n(reset_out_n), .reset_cfg(reset_cfg), .bus(bus.dev));
	cssr_host cssr_host_i (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .bus(bus.host));
	cssr_asserts cssr_asserts_i (.clk_sys(clk_sys), .rst(rst), .scl(bus.scl), .sda(bus.sda),
		.scl_o(bus.scl_o), .scl_oe(bus.scl_oe), .host_sda_o(bus.host_sda_o),
		.host_sda_oe(bus.host_sda_oe), .dev_sda_o(bus.dev_sda_o),
		.dev_sda_oe(bus.dev_sda_oe));

	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic hwr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_sys);
		wr    <= 1'b0;
	endtask : hwr

	// read data stand only in the cycle after the strobe
	task automatic hrd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys);
		rd   <= 1'b0;
		#1;
		d = rdata;
	endtask : hrd

	task automatic wait_stat(input int b, input logic val);
		for (n = 0; n < 20000; n++)
		begin
			hrd(cssr_pkg::HREG_STAT, v);
			if (v[b] === val)
				return;
		end
		errors++;
		tally_and_finish();
	endtask : wait_stat

	task automatic xfer(input logic [7:0] c, input logic [7:0] d, input logic [7:0] ctl);
		hwr(cssr_pkg::HREG_CMD, c);
		hwr(cssr_pkg::HREG_WDATA, d);
		hwr(cssr_pkg::HREG_CTRL, ctl);
		wait_stat(cssr_pkg::STAT_BUSY, 1'b0);
	endtask : xfer

	task automatic regrd(input logic [7:0] o, input logic [7:0] e);
		xfer(o, 8'h00, 8'h13);
		hrd(cssr_pkg::HREG_RX, v);
		check(v, e);
	endtask : regrd

	// fault for five cycles, then count cycles until reset output releases
	task automatic measure(input logic [3:0] bad, input logic lvl);
		@(posedge clk_sys);
		mon_good <= bad;
		repeat (4) @(posedge clk_sys);
		#1;
		check({7'h00, reset_out_n}, {7'h00, lvl});
		@(posedge clk_sys);
		mon_good <= 4'hF;
		#1;
		for (cnt = 0; cnt < 3000 && reset_out_n !== 1'b1; cnt++)
		begin
			@(posedge clk_sys);
			#1;
		end
		// a reset output that never releases ends the run here
		if (reset_out_n !== 1'b1)
		begin
			errors++;
			tally_and_finish();
		end
	endtask : measure

	task automatic wait_stall();
		int low;
		low = 0;
		for (n = 0; n < 20000 && low < 300; n++)
		begin
			@(posedge clk_sys);
			low = (bus.scl === 1'b0) ? low + 1 : 0;
		end
		check({7'h00, low >= 300}, 8'h01);
		if (low < 300)
			tally_and_finish();
	endtask : wait_stall

	initial
	begin
		rst = 1'b1;
		factory_erase = 1'b1;
		mon_good = 4'hF;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		errors = 0;
		comparisons = 0;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		factory_erase <= 1'b0;
		regrd(cssr_pkg::REG_RESET_CFG, 8'h00);
		regrd(cssr_pkg::REG_RESET_NV, 8'h00);
		check(reset_cfg, 8'h00);
		xfer(cssr_pkg::REG_RESET_CFG, 8'hA6, 8'h01);
		check(reset_cfg, 8'hA6);
		regrd(cssr_pkg::REG_RESET_CFG, 8'hA6);
		xfer(cssr_pkg::REG_RESET_NV, 8'hA6, 8'h01);
		regrd(cssr_pkg::REG_RESET_NV, 8'hA6);
		xfer(cssr_pkg::REG_RESET_CFG, 8'h5A, 8'h01);
		check(reset_cfg, 8'h5A);
		xfer(cssr_pkg::CMD_REBOOT, 8'h00, 8'h02);
		check(reset_cfg, 8'hA6);
		xfer(cssr_pkg::REG_RESET_CFG, 8'h3C, 8'h01);
		check(reset_cfg, 8'h3C);
		// a second reset stands in for a power cycle; the stored copy must survive
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		regrd(cssr_pkg::REG_RESET_CFG, 8'hA6);
		regrd(cssr_pkg::REG_RESET_NV, 8'hA6);
		// three-byte read with nothing popped: the master must hold the clock low
		hwr(cssr_pkg::HREG_CMD, 8'h10);
		hrd(cssr_pkg::HREG_CMD, v);
		check(v, 8'h10);
		hwr(cssr_pkg::HREG_CTRL, 8'h33);
		wait_stall();
		hrd(cssr_pkg::HREG_STAT, v);
		check({7'h00, v[cssr_pkg::STAT_BUSY]}, 8'h01);
		for (int k = 0; k < 3; k++)
		begin
			wait_stat(cssr_pkg::STAT_RXV, 1'b1);
			hrd(cssr_pkg::HREG_RX, v);
			check(v, (k == 1) ? 8'hA6 : 8'h00);
		end
		wait_stat(cssr_pkg::STAT_BUSY, 1'b0);
		check({7'h00, v[cssr_pkg::STAT_NAK]}, 8'h00);
		for (int c = 0; c < 8; c++)
		begin
			xfer(cssr_pkg::REG_RESET_CFG, {4'h8, 3'(c), 1'b0}, 8'h01);
			measure(4'hE, 1'b0);
			check({7'h00, cnt + 2 >= TMO_T[c] && cnt <= TMO_T[c] + 8}, 8'h01);
		end
		for (int i = 0; i < 4; i++)
		begin
			xfer(cssr_pkg::REG_RESET_CFG, (8'h80 >> i) | 8'h02, 8'h01);
			measure(~(4'h1 << i), 1'b0);
			check({7'h00, cnt <= TMO_T[1] + 8}, 8'h01);
			measure(~(4'h1 << ((i + 1) % 4)), 1'b1);
		end
		tally_and_finish();
	end
endmodule : cssr_tb_top
